// ===== verif/roifi_host.sv
// host model: issues quadlet requests to the inquiry bank
// assumes answers come on the same MCLK edge that takes the request
`timescale 1ns/1ps
`include "roifi_params.svh"

module roifi_host (
  input  wire logic                clk, // core clock
  output roifi_pkg::roifi_req_type req, // quadlet request
  input  roifi_pkg::roifi_rsp_type rsp  // quadlet answer
);
  initial req = '0;

  // one transfer by byte offset, link adds bus, node and base
  task automatic xfer(input logic w, input logic [11:0] ofs,
                      output roifi_pkg::roifi_rsp_type r);
    req <= '{1'h1, w, ofs, 32'hA5A5A5A5};
    @(posedge clk);
    // released request shows inverted values; answer stands until the next edge
    #1 req <= '{1'h0, ~w, ~ofs, 32'h5A5A5A5A};
    r = rsp;
    @(posedge clk);
    #1;
  endtask

  // raises a largest packet size until a frame fits in 4095 packets, or to 0xFFFC if none fits
  function automatic logic [15:0] fit_pkt(input logic [15:0] p, input logic [63:0] total);
    logic [63:0] need;
    need = (total + 64'hFFE) / 64'hFFF;
    need = (need + 64'h3) & ~64'h3;
    if (need > 64'hFFFC)
      return 16'hFFFC;
    if (64'(p) < need)
      return 16'(need);
    return p;
  endfunction

  // picks only codings the variant flags as supported
  function automatic logic [7:0] pick_code(input logic color, input logic [1:0] k);
    if (!color)
      return k[0] ? `ROIFI_ID_MONO16 : `ROIFI_ID_MONO8;
    case (k)
      2'h0: return `ROIFI_ID_MONO8;
      2'h1: return `ROIFI_ID_YUV422;
      2'h2: return `ROIFI_ID_RAW8;
      default: return `ROIFI_ID_RAW16;
    endcase
  endfunction
endmodule

// ===== verif/testbench.sv
// self-checking bench for the inquiry register bank
// assumes roifi_host as the requesting side and the design sources
`timescale 1ns/1ps
`include "roifi_params.svh"

module testbench;
  logic                     MCLK;
  logic                     RSTN;
  logic                     CE;
  logic                     COLOR_MODEL;
  logic [15:0]              MAX_PKT;
  logic [63:0]              exp_b;
  logic [11:0]              ofs [8];
  roifi_pkg::roifi_req_type REQ;
  roifi_pkg::roifi_cfg_type CFG;
  roifi_pkg::roifi_rsp_type RSP;
  roifi_pkg::roifi_rsp_type r;
  int                       n_errors;
  int                       checks_done;

  // clock, 4 ns period
  initial
  begin
    MCLK = 1'h0;
    forever #2 MCLK = ~MCLK;
  end

  roifi_regs i_dut (.MCLK(MCLK), .RSTN(RSTN), .CE(CE), .COLOR_MODEL(COLOR_MODEL),
                    .REQ(REQ), .CFG(CFG), .MAX_PKT(MAX_PKT), .RSP(RSP));
  roifi_host i_host (.clk(MCLK), .req(REQ), .rsp(RSP));

  // expected flags, code n at msb-first bit n
  function automatic logic [31:0] exp_codes(input logic color);
    logic [31:0] f;
    f = 32'h0;
    for (int n = 0; n < 11; n++)
      if (color ? (n == 0 || n == 2 || n == 9 || n == 10) : (n == 0 || n == 5))
        f[31-n] = 1'h1;
    return f;
  endfunction

  // expected bytes: image rounded to quadlet plus appended data
  function automatic logic [63:0] exp_bytes(input roifi_pkg::roifi_cfg_type c);
    logic [63:0] b;
    b = 64'(c.width) * 64'(c.height);
    if (c.code == 8'h02 || c.code == 8'h05 || c.code == 8'h0A)
      b = b * 2;
    else if (c.code != 8'h00 && c.code != 8'h09)
      b = 64'h0;
    return ((b + 64'h3) & ~64'h3) + 64'(c.extra);
  endfunction

  // compares one answer
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer and its expected answer
  task automatic acc(input logic w, input logic [11:0] o, input logic e,
                     input logic [31:0] d);
    i_host.xfer(w, o, r);
    chk(r, {1'h1, e, d});
  endtask

  // waits n edges, lands just after the last
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #40000;
    n_errors++;
    stop_test;
  end

  // main sequence
  initial
  begin
    RSTN = 1'h0;
    CE = 1'h1;
    COLOR_MODEL = 1'h0;
    MAX_PKT = 16'h0;
    CFG = '0;
    n_errors = 0;
    checks_done = 0;
    ofs = '{12'h014, 12'h034, 12'h038, 12'h03C, 12'h040, 12'h044, 12'h000, 12'hFFC};
    void'($urandom(32'hEE130145));
    cyc(6);
    RSTN = 1'h1;
    // coding flags per variant, writes leave them alone
    for (int v = 0; v < 2; v++)
    begin
      COLOR_MODEL = v[0];
      cyc(4);
      acc(1'h0, `ROIFI_OFS_CODING, 1'h0, exp_codes(v[0]));
      acc(1'h1, `ROIFI_OFS_CODING, 1'h0, 32'h0);
      acc(1'h0, `ROIFI_OFS_CODING, 1'h0, exp_codes(v[0]));
    end
    $display("test coding done");
    // random sizes, codes and appended data, corners first
    for (int i = 0; i < 30; i++)
    begin
      COLOR_MODEL = i[1];
      CFG.width = (i == 0) ? 16'hFFFF : 16'($urandom);
      CFG.height = (i == 0) ? 16'hFFFF : 16'($urandom);
      CFG.extra = (i == 1) ? 32'hFFFFFFFF : $urandom;
      CFG.code = i_host.pick_code(i[1], (i == 0) ? 2'h1 : 2'($urandom));
      exp_b = exp_bytes(CFG);
      MAX_PKT = i_host.fit_pkt(16'($urandom), exp_b);
      cyc(4);
      acc(1'h0, 12'h034, 1'h0, 32'(CFG.width) * 32'(CFG.height));
      acc(1'h0, `ROIFI_OFS_BYTE_HI, 1'h0, exp_b[63:32]);
      acc(1'h0, `ROIFI_OFS_BYTE_LO, 1'h0, exp_b[31:0]);
      acc(1'h0, `ROIFI_OFS_PKT, 1'h0, {16'h0004, MAX_PKT});
    end
    $display("test totals done");
    // writes everywhere, unmapped places answer with error
    foreach (ofs[k])
      acc(1'h1, ofs[k], 1'(k > 4), 32'h0);
    for (int k = 5; k < 8; k++)
      acc(1'h0, ofs[k], 1'h1, 32'h0);
    acc(1'h0, `ROIFI_OFS_PKT, 1'h0, {16'h0004, MAX_PKT});
    $display("test writes done");
    // size change while disabled stays unseen until enable returns
    exp_b = 64'(CFG.width) * 64'(CFG.height);
    CE = 1'h0;
    CFG.width = CFG.width ^ 16'h00FF;
    cyc(4);
    CE = 1'h1;
    acc(1'h0, `ROIFI_OFS_PIXCNT, 1'h0, exp_b[31:0]);
    exp_b = exp_bytes(CFG);
    acc(1'h0, `ROIFI_OFS_PIXCNT, 1'h0, 32'(CFG.width) * 32'(CFG.height));
    acc(1'h0, `ROIFI_OFS_BYTE_LO, 1'h0, exp_b[31:0]);
    $display("test enable done");
    stop_test;
  end
endmodule

// ===== verilog/roifi_byte_calc.sv
// per-frame pixel count and byte total, two register stages
// assumes settings come from logic on the same clock
`timescale 1ns/1ps
`include "roifi_params.svh"

module roifi_byte_calc (
  input  wire logic                  clk,       // core clock
  input  wire logic                  rst_n,     // sync reset, active low
  input  wire logic                  ce,        // clock enable
  input  roifi_pkg::roifi_cfg_type   cfg,       // current size and coding
  output logic [31:0]                pix_r,     // pixels per frame
  output logic [63:0]                bytes_r    // bytes per frame
);

  logic [31:0] pix_nxt;
  logic [63:0] bytes_nxt;
  logic [2:0]  bpp_r;
  logic [2:0]  bpp_nxt;
  logic [31:0] extra_r;
  logic [31:0] extra_nxt;
  logic [63:0] raw;

  // stage one: pixel count and bytes per pixel from the coding
  always_comb
  begin
    pix_nxt   = pix_r;
    bpp_nxt   = bpp_r;
    extra_nxt = extra_r;
    bytes_nxt = bytes_r;
    raw       = 64'h0;
    if (ce)
    begin
      pix_nxt   = {16'h0, cfg.width} * {16'h0, cfg.height};
      extra_nxt = cfg.extra;
      case (cfg.code)
        `ROIFI_ID_MONO8:  bpp_nxt = 3'h1;
        `ROIFI_ID_YUV422: bpp_nxt = 3'h2;
        `ROIFI_ID_MONO16: bpp_nxt = 3'h2;
        `ROIFI_ID_RAW8:   bpp_nxt = 3'h1;
        `ROIFI_ID_RAW16:  bpp_nxt = 3'h2;
        default:          bpp_nxt = 3'h0;
      endcase
      // stage two: image bytes, quadlet padding, appended feature data
      raw       = {32'h0, pix_r} * {61'h0, bpp_r};
      bytes_nxt = ((raw + `ROIFI_QUAD_ROUND) & `ROIFI_QUAD_MASK)
                  + {32'h0, extra_r};
    end
  end

  // stage registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pix_r   <= 32'h0;
      bpp_r   <= 3'h0;
      extra_r <= 32'h0;
      bytes_r <= 64'h0;
    end
    else
    begin
      pix_r   <= pix_nxt;
      bpp_r   <= bpp_nxt;
      extra_r <= extra_nxt;
      bytes_r <= bytes_nxt;
    end
  end

endmodule

// ===== verilog/roifi_params.svh
// constants for the area-of-interest inquiry register bank
// assumes byte offsets relative to the format's register base
`ifndef ROIFI_PARAMS_SVH
`define ROIFI_PARAMS_SVH

// register byte offsets
`define ROIFI_OFS_CODING   12'h014
`define ROIFI_OFS_PIXCNT   12'h034
`define ROIFI_OFS_BYTE_HI  12'h038
`define ROIFI_OFS_BYTE_LO  12'h03C
`define ROIFI_OFS_PKT      12'h040

// supported coding sets, bit n = pixel_format_code n
`define ROIFI_CODES_MONO   11'h021
`define ROIFI_CODES_COLOR  11'h605
`define ROIFI_NUM_CODES    11

// pixel_format_code values
`define ROIFI_ID_MONO8     8'h00
`define ROIFI_ID_YUV422    8'h02
`define ROIFI_ID_MONO16    8'h05
`define ROIFI_ID_RAW8      8'h09
`define ROIFI_ID_RAW16     8'h0A

// packet size step in bytes
`define ROIFI_PKT_STEP     16'h0004
// quadlet padding
`define ROIFI_QUAD_ROUND   64'h0000000000000003
`define ROIFI_QUAD_MASK    64'hFFFFFFFFFFFFFFFC

`endif

// ===== verilog/roifi_pkg.sv
// types for the area-of-interest inquiry register bank
// assumes quadlet requests arrive already decoded from the serial bus link
package roifi_pkg;

  // one quadlet request from the link layer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] offset;
    logic [31:0] wdata;
  } roifi_req_type;

  // one quadlet answer to the link layer
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } roifi_rsp_type;

  // area-of-interest settings from the writable registers
  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
    logic [7:0]  code;
    logic [31:0] extra;
  } roifi_cfg_type;

endpackage

// ===== verilog/roifi_regs.sv
// read-only inquiry registers of the area-of-interest image format
// assumes quadlet requests decoded by the serial bus link on MCLK
//
// Operation
// - coding inquiry holds one support flag per coding, one means supported
// - flag for code n sits at bit n, codes 0 to 10; 11-31 reserved
// - monochrome variant flags only codes 0 and 5
// - colour variant flags codes 0, 2, 9 and 10
// - pixel count register reports width times height
// - 64-bit byte total, upper quadlet at 0x38, lower at 0x3C
// - byte total counts image data, padding and appended feature data
// - byte total follows current image size and selected coding
// - packet step of 4 bytes in bits 0 to 15
// - bit 0 is the most significant bit of each register
`timescale 1ns/1ps
`include "roifi_params.svh"

module roifi_regs (
  input  wire logic                  MCLK,        // core clock, 250 MHz
  input  wire logic                  RSTN,        // sync reset, active low
  input  wire logic                  CE,          // clock enable
  input  wire logic                  COLOR_MODEL, // strap pin, 1 = colour
  input  roifi_pkg::roifi_req_type   REQ,         // quadlet request
  input  roifi_pkg::roifi_cfg_type   CFG,         // current size and coding
  input  wire logic [15:0]           MAX_PKT,     // largest packet in bytes
  output roifi_pkg::roifi_rsp_type   RSP          // quadlet answer
);

  logic        color_meta_r;
  logic        color_meta_nxt;
  logic        color_sync_r;
  logic        color_sync_nxt;
  logic [10:0] codes;
  logic [31:0] coding_word;
  logic [31:0] pix_r;
  logic [63:0] bytes_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        valid_r;
  logic        valid_nxt;
  logic        err_r;
  logic        err_nxt;

  // pixel count and byte total
  roifi_byte_calc u_calc (
    .clk     (MCLK),
    .rst_n   (RSTN),
    .ce      (CE),
    .cfg     (CFG),
    .pix_r   (pix_r),
    .bytes_r (bytes_r)
  );

  // strap synchroniser next values
  always_comb
  begin
    color_meta_nxt = color_meta_r;
    color_sync_nxt = color_sync_r;
    if (CE)
    begin
      color_meta_nxt = COLOR_MODEL;
      color_sync_nxt = color_meta_r;
    end
  end

  // strap synchroniser registers
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      color_meta_r <= 1'b0;
      color_sync_r <= 1'b0;
    end
    else
    begin
      color_meta_r <= color_meta_nxt;
      color_sync_r <= color_sync_nxt;
    end
  end

  // supported set per model variant
  assign codes = color_sync_r ? `ROIFI_CODES_COLOR : `ROIFI_CODES_MONO;

  // place flag n at msb-first bit n
  genvar n;
  generate
    for (n = 0; n < 32; n = n + 1)
    begin : g_flag
      if (n < `ROIFI_NUM_CODES)
      begin : g_used
        assign coding_word[31-n] = codes[n];
      end
      else
      begin : g_rsvd
        assign coding_word[31-n] = 1'b0;
      end
    end
  endgenerate

  // decode a request into the next answer
  always_comb
  begin
    valid_nxt = valid_r;
    err_nxt   = err_r;
    rdata_nxt = rdata_r;
    if (CE)
    begin
      valid_nxt = REQ.valid;
      err_nxt   = 1'b0;
      rdata_nxt = 32'h0;
      if (REQ.valid)
      begin
        case (REQ.offset)
          `ROIFI_OFS_CODING:  rdata_nxt = coding_word;
          `ROIFI_OFS_PIXCNT:  rdata_nxt = pix_r;
          `ROIFI_OFS_BYTE_HI: rdata_nxt = bytes_r[63:32];
          `ROIFI_OFS_BYTE_LO: rdata_nxt = bytes_r[31:0];
          `ROIFI_OFS_PKT:     rdata_nxt = {`ROIFI_PKT_STEP, MAX_PKT};
          default:            err_nxt   = 1'b1;
        endcase
        if (REQ.write)
        begin
          rdata_nxt = 32'h0;
        end
      end
    end
  end

  // answer registers
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      valid_r <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h0;
    end
    else
    begin
      valid_r <= valid_nxt;
      err_r   <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // answer outputs
  assign RSP.valid = valid_r;
  assign RSP.err   = err_r;
  assign RSP.rdata = rdata_r;

  // checks on the answer path and the byte total
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // helpers for the assertions
  logic rd_coding;
  logic rd_pkt;
  logic rd_any;
  assign rd_any    = CE && REQ.valid && !REQ.write;
  assign rd_coding = rd_any && REQ.offset == `ROIFI_OFS_CODING;
  assign rd_pkt    = rd_any && REQ.offset == `ROIFI_OFS_PKT;

  rsp_timing_a: assert property (
    CE && REQ.valid |=> RSP.valid)
    else $error("request not answered one cycle later");

  rsp_idle_a: assert property (
    CE && !REQ.valid |=> !RSP.valid)
    else $error("answer without request");

  mono_codes_a: assert property (
    rd_coding && !color_sync_r |=> RSP.rdata == 32'h84000000)
    else $error("monochrome coding flags wrong");

  color_codes_a: assert property (
    rd_coding && color_sync_r |=> RSP.rdata == 32'hA0600000)
    else $error("colour coding flags wrong");

  coding_rsvd_a: assert property (
    rd_coding |=> RSP.rdata[20:0] == 21'h0 && !RSP.err)
    else $error("reserved coding bits set");

  pix_count_a: assert property (
    rd_any && REQ.offset == `ROIFI_OFS_PIXCNT |=> RSP.rdata == $past(pix_r))
    else $error("pixel count read wrong");

  byte_hi_a: assert property (
    rd_any && REQ.offset == `ROIFI_OFS_BYTE_HI |=> RSP.rdata == $past(bytes_r[63:32]))
    else $error("upper byte total wrong");

  byte_lo_a: assert property (
    rd_any && REQ.offset == `ROIFI_OFS_BYTE_LO |=> RSP.rdata == $past(bytes_r[31:0]))
    else $error("lower byte total wrong");

  pkt_step_a: assert property (
    rd_pkt |=> RSP.rdata[31:16] == 16'h0004)
    else $error("packet step not 4");

  pkt_max_a: assert property (
    rd_pkt |=> RSP.rdata[15:0] == $past(MAX_PKT))
    else $error("largest packet field wrong");

  write_ignored_a: assert property (
    CE && REQ.valid && REQ.write |=> RSP.rdata == 32'h0)
    else $error("write returned data");

  byte_track_a: assert property (
    CE [*3] ##0 $stable(CFG) [*3] |-> bytes_r >= {32'h0, pix_r} + {32'h0, $past(CFG.extra)})
    else $error("byte total below pixels plus extra");

  // main scenarios
  cov_rd_coding: cover property (rd_coding ##1 RSP.valid);
  cov_rd_bytes:  cover property (rd_any && REQ.offset == `ROIFI_OFS_BYTE_HI
                                 ##1 rd_any && REQ.offset == `ROIFI_OFS_BYTE_LO);
  cov_unmapped:  cover property (RSP.valid && RSP.err);
  cov_write:     cover property (CE && REQ.valid && REQ.write ##1 RSP.valid);

endmodule
